//--- rtl/wd_pkg.sv
// Constants for the minute/second watchdog block.
// Assumes a 40 MHz system clock and a synchronous, active-low reset.
package wd_pkg;
    localparam int CLK_HZ = 40000000;
    // One second expressed in clock cycles; large, so the top exposes it as a parameter.
    localparam int SEC_CYCLES = CLK_HZ / 1;
    localparam int SEC_PER_MIN = 60;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam int UNIT_MIN_BIT = 7;
    localparam int FORCE_BIT = 2;
    localparam int STATUS_BIT = 0;
    localparam int KBD_EN_BIT = 0;
    localparam int MSE_EN_BIT = 1;
    localparam int CHAN_LSB = 4;
    localparam int CHAN_W = 4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } wd_state_t;
endpackage

//--- rtl/minute_second_watchdog.sv
// Minute/second watchdog counter with restart events and interrupt routing.
// Assumes host writes arrive as one-cycle strobes with data, synchronous to clk_i.
`timescale 1ns/1ps

// Operation
// RULE1 - The reload value accepted is 1 to 255 units of minutes or seconds.
// RULE2 - Bit 7 of the unit configuration selects minutes when set, else seconds.
// RULE3 - A reload value of zero disables the watchdog and is the reset value.
// RULE4 - Writing a non-zero reload value loads the counter and starts counting down.
// RULE5 - At zero the counter stops and the timeout status bit is set.
// RULE6 - A host control write may set or clear the status bit in any state.
// RULE7 - Software programs X plus one to get at least X units, as the first unit is partial; here the prescaler restarts on load, so it is whole.
// RULE8 - Keyboard and mouse interrupts are restart events, each with its own enable.
// RULE9 - An enabled restart event reloads the counter and clears the status bit.
// RULE10 - With both enables clear, keyboard and mouse interrupts do nothing.
// RULE11 - The status bit can raise an interrupt on a chosen channel.
// RULE12 - The chosen channel request follows the status bit level.
// RULE13 - Writing one to the force bit zeroes the counter and sets the status bit.
// RULE14 - The force bit clears itself and reads back as zero.
// RULE15 - Second and minute ticks come from a prescaler restarted on every reload.
// RULE16 - A new non-zero reload after expiry restarts counting; status stays until cleared.
module minute_second_watchdog
    import wd_pkg::*;
#(
    parameter int SEC_CYC    = SEC_CYCLES,
    parameter int NUM_CHAN   = 16
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    // Host writes
    input  wire logic                unit_wr_i,
    input  wire logic                reload_wr_i,
    input  wire logic                ctrl_wr_i,
    input  wire logic                evcfg_wr_i,
    input  wire logic [7:0]          wdata_i,
    // Restart events, one-cycle pulses
    input  wire logic                kbd_irq_i,
    input  wire logic                mse_irq_i,
    // Read-back and interrupt outputs
    output logic [7:0]               wd_unit_config_o,
    output logic [7:0]               wd_reload_value_o,
    output logic [7:0]               wd_control_o,
    output logic [7:0]               wd_event_config_o,
    output logic [7:0]               count_o,
    output logic [NUM_CHAN-1:0]      irq_o
);
    logic [7:0]  unit_ff;
    logic [7:0]  reload_ff;
    logic [7:0]  evcfg_ff;
    logic [7:0]  cnt_ff;
    logic        status_ff;
    logic [31:0] pre_ff;
    logic [5:0]  min_ff;
    wd_state_t   state_ff;
    logic        restart;
    logic        load;
    logic        force_to;
    logic        sec_tick;
    logic        unit_tick;

    assign restart  = (kbd_irq_i && evcfg_ff[KBD_EN_BIT]) ||
                      (mse_irq_i && evcfg_ff[MSE_EN_BIT]); // RULE8 RULE10
    assign load     = (reload_wr_i && (wdata_i != 8'h00)) || (restart && reload_ff != 8'h00);
    assign force_to = ctrl_wr_i && wdata_i[FORCE_BIT];
    assign sec_tick = (pre_ff == 32'(SEC_CYC - 1));
    assign unit_tick = sec_tick &&
        (!unit_ff[UNIT_MIN_BIT] || min_ff == 6'(SEC_PER_MIN - 1)); // RULE2

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            unit_ff  <= 8'h00;
            evcfg_ff <= 8'h00;
        end else begin
            if (unit_wr_i)
                unit_ff <= wdata_i;
            if (evcfg_wr_i)
                evcfg_ff <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            reload_ff <= RELOAD_RST; // RULE3
        else if (reload_wr_i)
            reload_ff <= wdata_i; // RULE1
    end

    // Prescaler restarts on reload so every countdown begins on a unit boundary.
    always_ff @(posedge clk_i) begin
        if (!rstn_i || load || state_ff != ST_RUN) begin
            pre_ff <= 32'h0000_0000; // RULE15
            min_ff <= 6'h00;
        end else if (sec_tick) begin
            pre_ff <= 32'h0000_0000;
            min_ff <= (min_ff == 6'(SEC_PER_MIN - 1)) ? 6'h00 : min_ff + 6'h01;
        end else begin
            pre_ff <= pre_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_ff   <= 8'h00;
            state_ff <= ST_IDLE;
        end else if (force_to) begin
            cnt_ff   <= 8'h00; // RULE13
            state_ff <= ST_DONE;
        end else if (reload_wr_i) begin
            cnt_ff   <= wdata_i; // RULE4 RULE16
            state_ff <= (wdata_i != 8'h00) ? ST_RUN : ST_IDLE; // RULE3
        end else if (load) begin
            cnt_ff   <= reload_ff; // RULE9
            state_ff <= ST_RUN;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (unit_tick) begin
                        cnt_ff <= cnt_ff - 8'h01;
                        if (cnt_ff == 8'h01)
                            state_ff <= ST_DONE; // RULE5
                    end
                end
                ST_IDLE: state_ff <= ST_IDLE;
                ST_DONE: state_ff <= ST_DONE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Hardware set wins over a host clear arriving in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            status_ff <= 1'b0;
        else if (force_to || (state_ff == ST_RUN && unit_tick && cnt_ff == 8'h01))
            status_ff <= 1'b1; // RULE5 RULE13
        else if (ctrl_wr_i)
            status_ff <= wdata_i[STATUS_BIT]; // RULE6
        else if (restart)
            status_ff <= 1'b0; // RULE9
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wd_unit_config_o  <= 8'h00;
            wd_reload_value_o <= 8'h00;
            wd_control_o      <= 8'h00;
            wd_event_config_o <= 8'h00;
            count_o           <= 8'h00;
        end else begin
            wd_unit_config_o  <= unit_ff;
            wd_reload_value_o <= reload_ff;
            wd_control_o      <= {7'h00, status_ff}; // RULE14
            wd_event_config_o <= evcfg_ff;
            count_o           <= cnt_ff;
        end
    end

    // Channel field zero means unmapped; channels 1..NUM_CHAN-1 follow the status level.
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_irq
            always_ff @(posedge clk_i) begin
                if (!rstn_i)
                    irq_o[g] <= 1'b0;
                else
                    irq_o[g] <= (g != 0) && status_ff &&
                        (evcfg_ff[CHAN_LSB +: CHAN_W] == CHAN_W'(g)); // RULE11 RULE12
            end
        end
    endgenerate

    AST_FORCE_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
        force_to |=> cnt_ff == 8'h00 && status_ff && state_ff == ST_DONE) // RULE13
        else $error("force did not zero the counter");
    AST_FORCE_SELFCLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        force_to |=> ##1 wd_control_o[FORCE_BIT] == 1'b0 && wd_control_o[STATUS_BIT]) // RULE14
        else $error("force bit read back set");
    AST_ZERO_DISABLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        reload_wr_i && wdata_i == 8'h00 && !force_to |=> state_ff == ST_IDLE) // RULE3
        else $error("zero reload did not disable");
    AST_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        reload_wr_i && wdata_i != 8'h00 && !force_to
        |=> cnt_ff == $past(wdata_i) && state_ff == ST_RUN && pre_ff == 0) // RULE4 RULE15 RULE16
        else $error("reload write did not start the count");
    AST_EXPIRE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_ff == ST_RUN && unit_tick && cnt_ff == 8'h01 && !load && !force_to
        && !reload_wr_i
        |=> state_ff == ST_DONE && status_ff && cnt_ff == 8'h00) // RULE5
        else $error("expiry did not stop and flag");
    AST_STOPPED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_ff == ST_DONE && !load && !reload_wr_i |=> $stable(cnt_ff)) // RULE5
        else $error("counter moved after stopping");
    AST_HOST_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_wr_i && !wdata_i[STATUS_BIT] && !force_to
        && !(state_ff == ST_RUN && unit_tick && cnt_ff == 8'h01) |=> !status_ff) // RULE6
        else $error("host clear of status ignored");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (!rstn_i)
        restart && !ctrl_wr_i && !reload_wr_i && !force_to && reload_ff != 8'h00
        && !(state_ff == ST_RUN && unit_tick && cnt_ff == 8'h01)
        |=> cnt_ff == reload_ff && !status_ff) // RULE9
        else $error("restart event did not reload");
    AST_NO_EVENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        evcfg_ff[1:0] == 2'b00 && !reload_wr_i && !force_to && !evcfg_wr_i
        && state_ff != ST_RUN |=> $stable(cnt_ff) && $stable(reload_ff)) // RULE10
        else $error("disabled event changed the counter");
    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        evcfg_ff[CHAN_LSB +: CHAN_W] == 4'h5 && $stable(evcfg_ff)
        |=> irq_o[5] == $past(status_ff)) // RULE11 RULE12
        else $error("mapped channel does not follow status");
    AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        evcfg_ff[CHAN_LSB +: CHAN_W] == 4'h0 |=> irq_o == '0) // RULE11
        else $error("unmapped watchdog raised a request line");
    AST_MIN_UNIT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_ff == ST_RUN && unit_ff[UNIT_MIN_BIT] && min_ff != 6'(SEC_PER_MIN - 1)
        && !load && !reload_wr_i && !force_to |=> $stable(cnt_ff)) // RULE2
        else $error("minute count moved between minute ticks");

    // A forced timeout shows up in two steps: the internal flag first, its copy a cycle later.
    sequence s_force_req;
        force_to;
    endsequence
    sequence s_force_seen;
        ##1 (status_ff && cnt_ff == 8'h00)
        ##1 (wd_control_o[STATUS_BIT] && !wd_control_o[FORCE_BIT] && count_o == 8'h00);
    endsequence
    AST_FORCE_STEPS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_force_req |-> s_force_seen) // RULE13 RULE14
        else $error("forced timeout not shown on the outputs");
endmodule

//--- bench/tb.sv
// Self-checking bench for the minute/second watchdog block.
// Assumes the design's own assertions run alongside; a short second is set here.
`timescale 1ns/1ps
module tb;
    import wd_pkg::*;
    localparam int SC = 4;
    localparam int MN = SC * SEC_PER_MIN;
    logic       clk_i = 1'b0, rstn_i = 1'b0;
    logic       unit_wr_i = 1'b0, reload_wr_i = 1'b0, ctrl_wr_i = 1'b0, evcfg_wr_i = 1'b0;
    logic       kbd_irq_i = 1'b0, mse_irq_i = 1'b0;
    logic [7:0] wdata_i = 8'h00, ucfg, rval, ctrl, ecfg, cnt, c;
    logic [15:0] irq;
    int num_errors = 0, check_count = 0, cyc = 0, n;
    always #12.5 clk_i = ~clk_i;
    minute_second_watchdog #(.SEC_CYC(SC), .NUM_CHAN(16)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .unit_wr_i(unit_wr_i), .reload_wr_i(reload_wr_i),
        .ctrl_wr_i(ctrl_wr_i), .evcfg_wr_i(evcfg_wr_i), .wdata_i(wdata_i),
        .kbd_irq_i(kbd_irq_i), .mse_irq_i(mse_irq_i), .wd_unit_config_o(ucfg),
        .wd_reload_value_o(rval), .wd_control_o(ctrl), .wd_event_config_o(ecfg),
        .count_o(cnt), .irq_o(irq));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // A hang is cut short well beyond the longest minute countdown below.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(int k);
        repeat (k) @(posedge clk_i);
        #2;
    endtask
    // Strobe for one edge, then allow two more edges for the outputs to mirror it.
    task automatic wr(int sel, logic [7:0] d);
        wdata_i = d;
        case (sel)
            0: unit_wr_i = 1'b1;
            1: reload_wr_i = 1'b1;
            2: ctrl_wr_i = 1'b1;
            default: evcfg_wr_i = 1'b1;
        endcase
        step(1);
        {unit_wr_i, reload_wr_i, ctrl_wr_i, evcfg_wr_i} = 4'h0;
        step(2);
    endtask
    task automatic pulse(bit mouse);
        if (mouse) mse_irq_i = 1'b1;
        else kbd_irq_i = 1'b1;
        step(1);
        {kbd_irq_i, mse_irq_i} = 2'b00;
        step(2);
    endtask
    task automatic wait_status(int lim);
        n = 0;
        while (ctrl[STATUS_BIT] !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic t_seconds();
        wr(0, 8'h00);
        wr(3, 8'h50);
        wr(1, 8'h03);
        chk("count", cnt, 16'h0003);
        wait_status(4 * SC + 8);
        chk("ctrl", ctrl, 16'h0001);
        chk("span", 16'(n >= 2 * SC && n <= 3 * SC + 4), 16'h0001);
        chk("xplus1", 16'(n >= 2 * SC), 16'h0001);
        chk("irq", irq, 16'h0020);
        step(3 * SC);
        chk("stop", cnt, 16'h0000);
        wr(2, 8'h00);
        chk("ctrl", ctrl, 16'h0000);
        chk("irq", irq, 16'h0000);
        wr(2, 8'h01);
        chk("ctrl", ctrl, 16'h0001);
    endtask
    task automatic t_events();
        wr(0, 8'h80);
        chk("unit", ucfg, 16'h0080);
        wr(3, 8'h53);
        chk("evcfg", ecfg, 16'h0053);
        wr(1, 8'h05);
        step(MN + 10);
        chk("min", cnt, 16'h0004);
        pulse(1'b0);
        chk("kbd", cnt, 16'h0005);
        chk("ctrl", ctrl, 16'h0000);
        wr(2, 8'h01);
        pulse(1'b1);
        chk("mse", ctrl, 16'h0000);
        wr(3, 8'h50);
        step(MN);
        c = cnt;
        pulse(1'b0);
        pulse(1'b1);
        chk("off", cnt, 16'(c));
        chk("rval", rval, 16'h0005);
    endtask
    task automatic t_force();
        wr(2, 8'h04);
        chk("fcnt", cnt, 16'h0000);
        chk("fctl", ctrl, 16'h0001);
        wr(1, 8'h02);
        chk("re", cnt, 16'h0002);
        chk("keep", ctrl, 16'h0001);
        wr(2, 8'h00);
        wait_status(3 * MN + 8);
        chk("mspan", 16'(n >= MN && n <= 2 * MN + 4), 16'h0001);
        wr(0, 8'h00);
        wr(2, 8'h00);
        wr(1, 8'h00);
        step(8 * SC);
        chk("dis", ctrl, 16'h0000);
        wr(3, 8'h00);
        wr(2, 8'h01);
        chk("unmap", irq, 16'h0000);
        wr(3, 8'h01);
        pulse(1'b0);
        chk("zctl", ctrl, 16'h0000);
        chk("zcnt", cnt, 16'h0000);
    endtask
    initial begin
        step(5);
        rstn_i = 1'b1;
        chk("rval", rval, 16'h0000);
        chk("ctrl", ctrl, 16'h0000);
        chk("irq", irq, 16'h0000);
        t_seconds();
        t_events();
        t_force();
        report_and_stop();
    end
endmodule
